// ==== rtl/osc_select_pll_refclk_ctrl.v ====
// clock-source selection, system pll setup and reference clock output
// assumes an ahb-lite master on hclk; ready, fail and source clocks
// are asynchronous; straps, unlock and power-state inputs are on hclk
`timescale 1ns/1ps
`include "osc_select_pll_refclk_ctrl_map.vh"

module osc_select_pll_refclk_ctrl (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // configuration word and unlock state
  input wire [2:0] default_source_config,
  input wire two_speed_startup_config,
  input wire secondary_osc_config,
  input wire pll_input_config,
  input wire system_unlocked,
  // oscillator status, asynchronous
  input wire [4:0] source_ready,
  input wire fail_safe_clock_monitor,
  // power management
  input wire wait_execute,
  input wire in_idle,
  input wire in_sleep,
  output reg sleep_entry,
  output reg idle_entry,
  // clock tree controls
  output reg [2:0] current_source_status,
  output reg [2:0] fast_rc_postdivider,
  output reg secondary_osc_enable,
  output reg pll_input_select,
  output reg [6:0] pll_multiplier,
  output reg [2:0] pll_output_divider,
  // reference clock
  input wire [6:0] ref_source_clocks,
  output reg ref_clock_out_pin,
  output wire ref_clock_out_oe
);

  // ==========================================================
  // state
  localparam SW_IDLE = 2'd0;
  localparam SW_WAIT = 2'd1;
  localparam SW_DONE = 2'd2;

  reg [2:0] new_source_select;
  reg selection_lock;
  reg sleep_on_wait_enable;
  reg clock_fail_flag;
  reg switch_enable;
  reg [1:0] sw_state;
  reg [2:0] sw_target;
  reg cfg_load;
  reg [14:0] ref_divider;
  reg ref_on;
  reg stop_in_idle;
  reg ref_oe;
  reg ref_run_in_sleep;
  reg divider_switch;
  reg ref_active;
  reg [3:0] ref_source_select;
  reg [14:0] div_active;
  reg [14:0] div_count;
  // bus phase capture
  reg wr_pend;
  reg rd_pend;
  reg rd_wait;
  reg [7:0] addr_q;
  // synchronisers
  reg [4:0] rdy_meta;
  reg [4:0] rdy_sync;
  reg fail_meta;
  reg fail_sync;
  reg [6:0] rck_meta;
  reg [6:0] rck_sync;
  reg rck_prev;

  // ==========================================================
  // register images
  wire [31:0] osc_word = {5'h00, fast_rc_postdivider, 9'h000,
    current_source_status, 1'b0, new_source_select, selection_lock,
    2'b00, sleep_on_wait_enable, clock_fail_flag, 1'b0,
    secondary_osc_enable, switch_enable};
  wire [31:0] pll_word = {5'h00, pll_output_divider, 1'b0,
    pll_multiplier, 8'h00, pll_input_select, 7'h00};
  wire [31:0] ref_word = {1'b0, ref_divider, ref_on, 1'b0, stop_in_idle,
    ref_oe, ref_run_in_sleep, 1'b0, divider_switch, ref_active, 4'h0,
    ref_source_select};

  // ==========================================================
  // ahb-lite slave
  // reads insert one wait state so hrdata comes from a flop and sees
  // any write that finished in the cycle before
  wire take = hsel && hready && (htrans == `HTRANS_NONSEQ);
  assign hreadyout = !rd_wait;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      rd_wait <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      if (hready) begin
        wr_pend <= take && hwrite && (hsize == `HSIZE_WORD);
        rd_pend <= take && !hwrite;
        rd_wait <= take && !hwrite;
        if (take)
          addr_q <= haddr;
      end else begin
        rd_wait <= 1'b0;
      end
    end
  end

  // read data; unmapped words read zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend && rd_wait) begin
      case (addr_q & `BASE_MASK)
        `OSC_CTRL_OFS: hrdata <= osc_word;
        `PLL_CTRL_OFS: hrdata <= pll_word;
        `REF_CTRL_OFS: hrdata <= ref_word;
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // alias merge: plain write, or clear, set, toggle of bits written one
  function [31:0] merge;
    input [1:0] kind;
    input [31:0] old;
    input [31:0] data;
    begin
      case (kind)
        `ALIAS_CLR: merge = old & ~data;
        `ALIAS_SET: merge = old | data;
        `ALIAS_INV: merge = old ^ data;
        default: merge = data;
      endcase
    end
  endfunction

  wire [1:0] kind = addr_q[`ALIAS_BITS];
  wire osc_wr = wr_pend && ((addr_q & `BASE_MASK) == `OSC_CTRL_OFS)
    && system_unlocked;
  wire pll_wr = wr_pend && ((addr_q & `BASE_MASK) == `PLL_CTRL_OFS)
    && system_unlocked;
  wire ref_wr = wr_pend && ((addr_q & `BASE_MASK) == `REF_CTRL_OFS);
  wire [31:0] osc_new = merge(kind, osc_word, hwdata);
  wire [31:0] pll_new = merge(kind, pll_word, hwdata);
  wire [31:0] ref_new = merge(kind, ref_word, hwdata);

  // ==========================================================
  // synchronisers for asynchronous status and source clocks
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdy_meta <= 5'h00;
      rdy_sync <= 5'h00;
      fail_meta <= 1'b0;
      fail_sync <= 1'b0;
      rck_meta <= 7'h00;
      rck_sync <= 7'h00;
    end else begin
      rdy_meta <= source_ready;
      rdy_sync <= rdy_meta;
      fail_meta <= fail_safe_clock_monitor;
      fail_sync <= fail_meta;
      rck_meta <= ref_source_clocks;
      rck_sync <= rck_meta;
    end
  end

  // ready of a new-source code; the reserved code is never waited on
  reg tgt_ready;
  always @* begin
    case (sw_target)
      `SRC_PLL: tgt_ready = rdy_sync[`RDY_PLL];
      `SRC_PRIMARY: tgt_ready = rdy_sync[`RDY_PRIMARY];
      `SRC_SECONDARY: tgt_ready = rdy_sync[`RDY_SECONDARY];
      `SRC_LOW_RC: tgt_ready = rdy_sync[`RDY_LOW_RC];
      `SRC_RESERVED: tgt_ready = 1'b1;
      default: tgt_ready = rdy_sync[`RDY_RC];
    endcase
  end

  // ==========================================================
  // oscillator control, pll control and switch sequencer
  // straps are caught on the first edge after reset release, since an
  // asynchronous reset may only load constants
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_load <= 1'b1;
      new_source_select <= `SRC_RC_DIV;
      current_source_status <= `SRC_RC_DIV;
      selection_lock <= 1'b0;
      sleep_on_wait_enable <= 1'b0;
      clock_fail_flag <= 1'b0;
      secondary_osc_enable <= 1'b0;
      switch_enable <= 1'b0;
      fast_rc_postdivider <= 3'h0;
      sw_state <= SW_IDLE;
      sw_target <= `SRC_RC_DIV;
      pll_input_select <= 1'b0;
      pll_multiplier <= `PLL_MULT_RESET;
      pll_output_divider <= `PLL_ODIV_RESET;
    end else if (cfg_load) begin
      cfg_load <= 1'b0;
      new_source_select <= default_source_config;
      // two-speed start-up runs from fast rc until the switch lands
      current_source_status <= two_speed_startup_config ? `SRC_RC_DIV
        : default_source_config;
      switch_enable <= two_speed_startup_config;
      secondary_osc_enable <= secondary_osc_config;
      pll_input_select <= pll_input_config;
    end else begin
      // sequencer: wait ready, move clock, then clear switch-enable
      case (sw_state)
        SW_IDLE: begin
          if (switch_enable) begin
            sw_target <= new_source_select;
            sw_state <= SW_WAIT;
          end
        end
        SW_WAIT: begin
          if (tgt_ready) begin
            if (sw_target != `SRC_RESERVED)
              current_source_status <= sw_target;
            sw_state <= SW_DONE;
          end
        end
        SW_DONE: begin
          switch_enable <= 1'b0;
          sw_state <= SW_IDLE;
        end
        default: sw_state <= SW_IDLE;
      endcase
      if (osc_wr) begin
        fast_rc_postdivider <= osc_new[`OSC_RC_DIV];
        selection_lock <= osc_new[`OSC_LOCK];
        sleep_on_wait_enable <= osc_new[`OSC_SLEEP];
        clock_fail_flag <= osc_new[`OSC_FAIL];
        secondary_osc_enable <= osc_new[`OSC_SEC_EN];
        if (!selection_lock) begin
          new_source_select <= osc_new[`OSC_NEW];
          // a write of one beats the sequencer's clear
          if (osc_new[`OSC_SWITCH])
            switch_enable <= 1'b1;
        end
      end
      if (pll_wr && !selection_lock) begin
        pll_output_divider <= pll_new[`PLL_ODIV];
        pll_multiplier <= pll_new[`PLL_MULT];
        pll_input_select <= pll_new[`PLL_ICLK];
      end
      // a failure seen in the same cycle as a clear still sets
      if (fail_sync)
        clock_fail_flag <= 1'b1;
    end
  end

  // wait instruction becomes a sleep or idle request pulse
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_entry <= 1'b0;
      idle_entry <= 1'b0;
    end else begin
      sleep_entry <= wait_execute && sleep_on_wait_enable;
      idle_entry <= wait_execute && !sleep_on_wait_enable;
    end
  end

  // ==========================================================
  // reference clock control register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_divider <= 15'h0000;
      ref_on <= 1'b0;
      stop_in_idle <= 1'b0;
      ref_oe <= 1'b0;
      ref_run_in_sleep <= 1'b0;
      divider_switch <= 1'b0;
      ref_active <= 1'b0;
      ref_source_select <= `RSEL_SYS0;
      div_active <= 15'h0000;
    end else begin
      ref_active <= ref_on;
      // idle module or finished switch picks up the new divisor
      if (!ref_on || divider_switch)
        div_active <= ref_divider;
      if (divider_switch)
        divider_switch <= 1'b0;
      if (ref_wr) begin
        ref_divider <= ref_new[`REF_DIV];
        ref_on <= ref_new[`REF_ON];
        stop_in_idle <= ref_new[`REF_STOP_IDLE];
        ref_oe <= ref_new[`REF_OE];
        ref_run_in_sleep <= ref_new[`REF_RUN_SLEEP];
        ref_source_select <= ref_new[`REF_SEL];
        if (ref_new[`REF_DIVSW])
          divider_switch <= 1'b1;
      end
    end
  end

  // ==========================================================
  // reference source mux and divider
  // sources are sampled on hclk, so each must stay below half of it
  reg rck_sel;
  always @* begin
    case (ref_source_select)
      `RSEL_SYS0: rck_sel = rck_sync[`RCK_SYS];
      `RSEL_SYS1: rck_sel = rck_sync[`RCK_SYS];
      `RSEL_PRIMARY: rck_sel = rck_sync[`RCK_PRIMARY];
      `RSEL_RC: rck_sel = rck_sync[`RCK_RC];
      `RSEL_LOW_RC: rck_sel = rck_sync[`RCK_LOW_RC];
      `RSEL_SECONDARY: rck_sel = rck_sync[`RCK_SECONDARY];
      `RSEL_PLL: rck_sel = rck_sync[`RCK_PLL];
      `RSEL_PIN: rck_sel = rck_sync[`RCK_PIN];
      default: rck_sel = 1'b0;
    endcase
  end

  // run gating for idle and sleep
  wire sleep_ok = ref_run_in_sleep && (ref_source_select != `RSEL_SYS0);
  wire ref_run = ref_active
    && !(stop_in_idle && in_idle)
    && !(in_sleep && !sleep_ok);
  wire rck_rise = rck_sel && !rck_prev;

  // output toggles every divisor rising edges: divide by twice divisor
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rck_prev <= 1'b0;
      div_count <= 15'h0000;
      ref_clock_out_pin <= 1'b0;
    end else begin
      rck_prev <= rck_sel;
      if (!ref_run || divider_switch) begin
        div_count <= 15'h0000;
        ref_clock_out_pin <= 1'b0;
      end else if (div_active == 15'h0000) begin
        ref_clock_out_pin <= rck_sel;
      end else if (rck_rise) begin
        if (div_count >= div_active - 15'h0001) begin
          div_count <= 15'h0000;
          ref_clock_out_pin <= !ref_clock_out_pin;
        end else begin
          div_count <= div_count + 15'h0001;
        end
      end
    end
  end

  // pin driven only while output enable is set
  assign ref_clock_out_oe = ref_oe;

endmodule

// ==== rtl/osc_select_pll_refclk_ctrl_map.vh ====
// register map and field layout of the clock-control block
// assumes inclusion by bare name from the block's single design file
`ifndef OSC_SELECT_PLL_REFCLK_CTRL_MAP_VH
`define OSC_SELECT_PLL_REFCLK_CTRL_MAP_VH

// ==========================================================
// register word offsets (byte addresses, bits 7:0)
`define OSC_CTRL_OFS 8'h00
`define PLL_CTRL_OFS 8'h10
`define REF_CTRL_OFS 8'h20
`define BASE_MASK 8'hf0

// alias kinds, address bits 3:2
`define ALIAS_BITS 3:2
`define ALIAS_WRITE 2'h0
`define ALIAS_CLR 2'h1
`define ALIAS_SET 2'h2
`define ALIAS_INV 2'h3

// ==========================================================
// oscillator control fields
`define OSC_RC_DIV 26:24
`define OSC_CUR 14:12
`define OSC_NEW 10:8
`define OSC_LOCK 7
`define OSC_SLEEP 4
`define OSC_FAIL 3
`define OSC_SEC_EN 1
`define OSC_SWITCH 0

// system pll control fields
`define PLL_ODIV 26:24
`define PLL_MULT 22:16
`define PLL_ICLK 7
`define PLL_MULT_RESET 7'h01
`define PLL_ODIV_RESET 3'h0

// reference clock control fields
`define REF_DIV 30:16
`define REF_ON 15
`define REF_STOP_IDLE 13
`define REF_OE 12
`define REF_RUN_SLEEP 11
`define REF_DIVSW 9
`define REF_ACTIVE 8
`define REF_SEL 3:0

// ==========================================================
// new-source encodings
`define SRC_RC_DIV 3'h0
`define SRC_PLL 3'h1
`define SRC_PRIMARY 3'h2
`define SRC_RESERVED 3'h3
`define SRC_SECONDARY 3'h4
`define SRC_LOW_RC 3'h5

// ready vector bit positions
`define RDY_RC 0
`define RDY_PLL 1
`define RDY_PRIMARY 2
`define RDY_SECONDARY 3
`define RDY_LOW_RC 4

// reference source encodings
`define RSEL_SYS0 4'h0
`define RSEL_SYS1 4'h1
`define RSEL_PRIMARY 4'h2
`define RSEL_RC 4'h3
`define RSEL_LOW_RC 4'h4
`define RSEL_SECONDARY 4'h5
`define RSEL_PLL 4'h7
`define RSEL_PIN 4'h9

// reference clock input vector positions
`define RCK_SYS 0
`define RCK_PRIMARY 1
`define RCK_RC 2
`define RCK_LOW_RC 3
`define RCK_SECONDARY 4
`define RCK_PLL 5
`define RCK_PIN 6

// ahb encodings
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2

`endif

// ==== verification/osc_select_pll_refclk_ctrl_checker.sv ====
// port-level assertions for the clock-control block
// assumes it is bound into every instance of the design module
`timescale 1ns/1ps
// =====================================================
// checker
module osc_select_pll_refclk_ctrl_checker (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // register bus
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire system_unlocked,
  // power management
  input wire wait_execute,
  input wire sleep_entry,
  input wire idle_entry,
  // clock tree and reference output
  input wire [6:0] pll_multiplier,
  input wire [2:0] pll_output_divider,
  input wire ref_clock_out_pin,
  input wire ref_clock_out_oe
);
  wire taken;
  wire pll_wr_ok;
  wire ref_wr_seen;
  reg wr_dp;
  reg rd_dp;
  reg [3:0] dp_page;
  assign taken = hsel && hready && (htrans == 2'h2);
  // unlocked pll write and reference write in their data phase
  assign pll_wr_ok = wr_dp && system_unlocked && (dp_page == 4'h1);
  assign ref_wr_seen = wr_dp && (dp_page == 4'h2);
  // data phase tracker; advances only while the bus is ready
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp <= 1'b0;
      rd_dp <= 1'b0;
      dp_page <= 4'h0;
    end else if (hready) begin
      wr_dp <= taken && hwrite;
      rd_dp <= taken && !hwrite;
      dp_page <= haddr[7:4];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // bus answer timing
  chk_read_wait: assert property (
      taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase length wrong");
  chk_write_nowait: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  // read data only moves when a read completes
  chk_hrdata_hold: assert property ($changed(hrdata) |-> $past(rd_dp))
    else $error("read data changed without a read");
  // wait instruction gives exactly one kind of entry
  chk_wait_entry: assert property (
      wait_execute |=> sleep_entry ^ idle_entry)
    else $error("wait gave no single entry pulse");
  chk_entry_cause: assert property (
      (sleep_entry || idle_entry) |-> $past(wait_execute))
    else $error("entry pulse without wait");
  // pll fields move only through an unlocked pll write
  chk_mult_lock: assert property (
      $changed(pll_multiplier) |-> $past(pll_wr_ok))
    else $error("multiplier changed without unlocked write");
  chk_odiv_lock: assert property (
      $changed(pll_output_divider) |-> $past(pll_wr_ok))
    else $error("output divider changed without unlocked write");
  // pin drive changes only by a reference register write
  chk_oe_cause: assert property (
      $changed(ref_clock_out_oe) |-> $past(ref_wr_seen))
    else $error("output enable changed without write");
  cover property (taken && !hwrite);
  cover property (sleep_entry);
  cover property ($rose(ref_clock_out_pin));
endmodule

bind osc_select_pll_refclk_ctrl osc_select_pll_refclk_ctrl_checker
  i_osc_select_pll_refclk_ctrl_checker (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .system_unlocked(system_unlocked), .wait_execute(wait_execute),
  .sleep_entry(sleep_entry), .idle_entry(idle_entry),
  .pll_multiplier(pll_multiplier), .pll_output_divider(pll_output_divider),
  .ref_clock_out_pin(ref_clock_out_pin), .ref_clock_out_oe(ref_clock_out_oe));

// ==== verification/tb_osc_select_pll_refclk_ctrl.sv ====
// self-checking bench for the clock-control block
// assumes the design and its map header are on the compile path
`timescale 1ns/1ps
module tb_osc_select_pll_refclk_ctrl;
  typedef struct {logic [7:0] a; logic [31:0] d, m, e;} row_t;
  localparam logic [31:0] all_ones = 32'hffffffff;
  logic hclk, hresetn, hsel, hwrite, hrdy, hresp, src;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, dsc, cur, fdiv, odiv;
  logic [31:0] hwdata, hrdata, rd;
  logic two, soc, pcf, unl, fmon, wex, idl, slp, sle, ide, sos, pis, pin, oe;
  logic [4:0] rdy;
  logic [6:0] mult;
  int err_count, comparisons, cyc, h;
  row_t rows [8];

  osc_select_pll_refclk_ctrl i_osc_select_pll_refclk_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata),
    .default_source_config(dsc), .two_speed_startup_config(two),
    .secondary_osc_config(soc), .pll_input_config(pcf),
    .system_unlocked(unl), .source_ready(rdy),
    .fail_safe_clock_monitor(fmon), .wait_execute(wex), .in_idle(idl),
    .in_sleep(slp), .sleep_entry(sle), .idle_entry(ide),
    .current_source_status(cur), .fast_rc_postdivider(fdiv),
    .secondary_osc_enable(sos), .pll_input_select(pis),
    .pll_multiplier(mult), .pll_output_divider(odiv),
    .ref_source_clocks({7{src}}), .ref_clock_out_pin(pin),
    .ref_clock_out_oe(oe));

  // =====================================================
  // clocks; source edges sit 1 ns off hclk edges to avoid races
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    src = 1'b0;
    #1;
    forever #20 src = ~src;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish;
    end
  end

  // =====================================================
  // helpers
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // one single transfer; ready and read data taken at rising edges,
  // before the design's own updates of that edge land
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask
  task automatic per(input int e);
    time t0;
    @(posedge pin);
    t0 = $time;
    @(posedge pin);
    check(32'($time - t0), e);
  endtask
  // counts pin highs after letting the output settle
  task automatic held(output int n);
    n = 0;
    repeat (4) @(posedge hclk);
    repeat (40) begin
      @(negedge hclk);
      if (pin !== 1'b0) n++;
    end
    @(posedge hclk);
  endtask
  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask
  task tally_and_finish;
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // =====================================================
  // main sequence
  initial begin
    {hsel, htrans, haddr, hwrite, hwdata, hresetn} = '0;
    hsize = 3'h2;
    {dsc, two, soc, pcf, unl} = {3'h2, 1'b0, 1'b1, 1'b1, 1'b1};
    {rdy, fmon, wex, idl, slp} = '0;
    {err_count, comparisons, cyc} = '0;
    rows = '{'{8'h10, 32'h02060000, all_ones, 32'h02060000},
      '{8'h18, 32'h00000080, all_ones, 32'h02060080},
      '{8'h14, 32'h00060000, all_ones, 32'h02000080},
      '{8'h1c, 32'h07000000, all_ones, 32'h05000080},
      '{8'h00, 32'h03000012, all_ones, 32'h03002012},
      '{8'h0c, 32'h00000002, all_ones, 32'h03002010},
      '{8'h20, 32'h00051802, 32'hfffffcff, 32'h00051802},
      '{8'h30, all_ones, all_ones, 32'h0}};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rdc(8'h00, all_ones, 32'h00002202);
    rdc(8'h10, all_ones, 32'h00010080);
    rdc(8'h20, all_ones, 32'h0);
    check({pis, sos, odiv}, 5'h18);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a & 8'hf0, rows[i].m, rows[i].e);
    end
    check({mult, odiv}, 10'h005);
    check({hresp, fdiv}, 4'h3);
    // refused writes: locked system, then selection lock
    unl <= 1'b0;
    wr(8'h10, 32'h0);
    unl <= 1'b1;
    rdc(8'h10, all_ones, 32'h05000080);
    wr(8'h08, 32'h80);
    wr(8'h10, 32'h01030000);
    rdc(8'h10, all_ones, 32'h05000080);
    wr(8'h08, 32'h101);
    rdc(8'h00, all_ones, 32'h03002090);
    wr(8'h04, 32'h80);
    rdc(8'h00, all_ones, 32'h03002010);
    // wait instruction with sleep bit set, then clear
    for (int i = 0; i < 2; i++) begin
      wr(i ? 8'h04 : 8'h08, 32'h10);
      wex <= 1'b1;
      @(posedge hclk);
      wex <= 1'b0;
      @(negedge hclk);
      check({sle, ide}, i ? 2'b01 : 2'b10);
      @(posedge hclk);
    end
    fmon <= 1'b1;
    repeat (4) @(posedge hclk);
    fmon <= 1'b0;
    rdc(8'h00, 32'h8, 32'h8);
    // reference output: bypass, divisor 2 (divide by 4), idle, sleep
    wr(8'h20, 32'h00001003);
    wr(8'h28, 32'h8000);
    repeat (10) @(posedge hclk);
    check(oe, 1'b1);
    per(40);
    wr(8'h28, 32'h00020200);
    repeat (10) @(posedge hclk);
    rdc(8'h20, 32'h00030300, 32'h00020100);
    per(160);
    wr(8'h28, 32'h2000);
    idl <= 1'b1;
    held(h);
    check(h, 0);
    idl <= 1'b0;
    slp <= 1'b1;
    held(h);
    check(h, 0);
    wr(8'h28, 32'h800);
    per(160);
    slp <= 1'b0;
    wr(8'h24, 32'h1000);
    @(negedge hclk);
    check(oe, 1'b0);
    // second reset with other straps; switches wait for ready
    @(posedge hclk);
    {dsc, two, soc, pcf} <= {3'h4, 1'b1, 1'b0, 1'b0};
    do_reset;
    rdc(8'h00, all_ones, 32'h00000401);
    rdc(8'h10, all_ones, 32'h00010000);
    rdy <= 5'h08;
    repeat (10) @(posedge hclk);
    rdc(8'h00, all_ones, 32'h00004400);
    check({cur, sos}, 4'h8);
    wr(8'h00, 32'h101);
    rdc(8'h00, all_ones, 32'h00004101);
    rdy <= 5'h0a;
    repeat (10) @(posedge hclk);
    rdc(8'h00, all_ones, 32'h00001100);
    check(cur, 3'h1);
    tally_and_finish;
  end
endmodule
